// ---- bench/pdl_monitor.sv ----
/* checker for pdl_top lock, power-down and bus rules.
 * assumes aw and w are offered on the same edge. */
`timescale 1ns/1ns
module pdl_monitor (
	// clock and reset
	input wire        CLK,
	input wire        RSTN,
	// pll pins
	input wire        SYS_REF_CLK,
	input wire        USB_REF_CLK,
	input wire        SYS_CLK_OUT,
	input wire        SYS_LOCK,
	input wire        USB_LOCK,
	// register bus
	input wire [3:0]  AWADDR,
	input wire        AWVALID,
	input wire        AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0]  WSTRB,
	input wire        WVALID,
	input wire        WREADY,
	input wire        BVALID,
	input wire [3:0]  ARADDR,
	input wire        ARVALID,
	input wire        ARREADY,
	input wire [1:0]  RRESP,
	input wire        RVALID
);
	// ****
	// mirrored state
	// ****
	reg        sys_pd_q, usb_pd_q, byp_q, out_q, seen_q, sr_q, ur_q;
	reg [1:0]  psel_q;
	reg [3:0]  cnt_q, sys_e_q, usb_e_q;
	wire       w = AWVALID && AWREADY && WVALID && WREADY;
	wire       tog = SYS_CLK_OUT != out_q;
	wire [3:0] half = byp_q ? 4'h1 : 4'h1 << psel_q;
	// raw ref edges only loosen the bound: the dut sees them late
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			{sys_pd_q, usb_pd_q} <= 2'h3;
			{byp_q, psel_q, out_q, seen_q, sr_q, ur_q} <= 7'h0;
			{cnt_q, sys_e_q, usb_e_q} <= 12'h0;
		end else begin
			if (w && AWADDR == 4'h0 && WSTRB[1]) sys_pd_q <= WDATA[8];
			if (w && AWADDR == 4'h4 && WSTRB[1]) usb_pd_q <= WDATA[8];
			if (w && AWADDR == 4'h0 && WSTRB[0]) {byp_q, psel_q} <= WDATA[7:5];
			{out_q, sr_q, ur_q} <= {SYS_CLK_OUT, SYS_REF_CLK, USB_REF_CLK};
			cnt_q <= tog ? 4'h1 : cnt_q + 4'h1;
			seen_q <= !sys_pd_q && (seen_q || tog);
			if (sys_pd_q) sys_e_q <= 4'h0;
			else if (SYS_REF_CLK && !sr_q && sys_e_q != 4'hF) sys_e_q <= sys_e_q + 4'h1;
			if (usb_pd_q) usb_e_q <= 4'h0;
			else if (USB_REF_CLK && !ur_q && usb_e_q != 4'hF) usb_e_q <= usb_e_q + 4'h1;
		end
	end
	// ****
	// properties
	// ****
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	sequence both_s;
		w && AWADDR == 4'h0;
	endsequence
	sequence bad_rd_s;
		ARVALID && ARREADY && ARADDR == 4'hC;
	endsequence
	sys_pd_lock_a: assert property (sys_pd_q && $past(sys_pd_q, 3) |-> !SYS_LOCK)
		else $error("sys lock in power-down");
	usb_pd_lock_a: assert property (usb_pd_q && $past(usb_pd_q, 3) |-> !USB_LOCK)
		else $error("usb lock in power-down");
	sys_pd_clk_a: assert property (sys_pd_q && $past(sys_pd_q, 3) |-> !SYS_CLK_OUT)
		else $error("sys clock runs in power-down");
	sys_lock_rise_a: assert property ($rose(SYS_LOCK) |-> sys_e_q > 4'h8)
		else $error("sys lock too early");
	usb_lock_rise_a: assert property ($rose(USB_LOCK) |-> usb_e_q > 4'h8)
		else $error("usb lock too early");
	sys_half_per_a: assert property (tog && seen_q && !sys_pd_q |-> cnt_q == half)
		else $error("sys half period wrong");
	wr_resp_a: assert property (both_s |-> ##[1:2] BVALID)
		else $error("write response missing");
	rd_err_a: assert property (bad_rd_s |-> ##[1:2] RVALID && RRESP == 2'h2)
		else $error("unmapped read not refused");
endmodule
bind pdl_top pdl_monitor mon_u (.CLK(CLK), .RSTN(RSTN), .SYS_REF_CLK(SYS_REF_CLK),
	.USB_REF_CLK(USB_REF_CLK), .SYS_CLK_OUT(SYS_CLK_OUT), .SYS_LOCK(SYS_LOCK),
	.USB_LOCK(USB_LOCK), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
	.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RRESP(RRESP), .RVALID(RVALID));

// ---- bench/pdl_ref_model.sv ----
/* reference clock source standing in for the input mux.
 * assumes half periods in bench clock cycles; 0 stops the clock. */
`timescale 1ns/1ns
module pdl_ref_model (
	// clock
	input  wire       clk,
	// setting
	input  wire [7:0] half,
	// reference
	output reg        ref_clk
);
	reg [7:0] cnt_q;
	initial begin
		ref_clk = 1'b0;
		cnt_q = 8'h0;
	end
	// a stopped source sits low, as a gated mux output would
	always @(posedge clk) begin
		if (half == 8'h0) begin
			ref_clk <= 1'b0;
			cnt_q <= 8'h0;
		end else if (cnt_q + 8'h1 >= half) begin
			ref_clk <= !ref_clk;
			cnt_q <= 8'h0;
		end else begin
			cnt_q <= cnt_q + 8'h1;
		end
	end
endmodule

// ---- bench/pll_divider_lock_control_tb_top.sv ----
/* bench for pdl_top: axi4-lite tasks, reference sources, lock checks.
 * assumes the reference model and checker are compiled first. */
`timescale 1ns/1ns
`include "pdl_map.vh"
module pll_divider_lock_control_tb_top;
	reg         CLK = 1'b0;
	reg         RSTN = 1'b0;
	reg  [3:0]  AWADDR = 4'h0;
	reg  [3:0]  ARADDR = 4'h0;
	reg  [3:0]  WSTRB = 4'h0;
	reg  [31:0] WDATA = 32'h0;
	reg         AWVALID = 1'b0;
	reg         WVALID = 1'b0;
	reg         BREADY = 1'b0;
	reg         ARVALID = 1'b0;
	reg         RREADY = 1'b0;
	reg  [7:0]  sys_half = 8'h0;
	reg  [7:0]  usb_half = 8'h0;
	reg  [7:0]  cfg [0:4];
	reg         p;
	wire        SYS_REF_CLK, USB_REF_CLK, SYS_CLK_OUT, SYS_LOCK, USB_CLK_OUT, USB_LOCK;
	wire        AWREADY, WREADY, BVALID, ARREADY, RVALID;
	wire [1:0]  BRESP, RRESP;
	wire [31:0] RDATA;
	integer     num_errors = 0;
	integer     check_count = 0;
	integer     i, n, m, h, c;
	always #20 CLK = !CLK;
	pdl_ref_model sys_ref_u (.clk(CLK), .half(sys_half), .ref_clk(SYS_REF_CLK));
	pdl_ref_model usb_ref_u (.clk(CLK), .half(usb_half), .ref_clk(USB_REF_CLK));
	pdl_top dut_u (.CLK(CLK), .RSTN(RSTN), .SYS_REF_CLK(SYS_REF_CLK), .USB_REF_CLK(USB_REF_CLK),
		.SYS_CLK_OUT(SYS_CLK_OUT), .SYS_LOCK(SYS_LOCK), .USB_CLK_OUT(USB_CLK_OUT),
		.USB_LOCK(USB_LOCK), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
	// ****
	// tasks
	// ****
	task test_done;
		begin
			if (num_errors == 0 && check_count > 0) begin
				$display("SIMULATION PASSED");
			end else begin
				$display("SIMULATION FAILED");
			end
			$finish;
		end
	endtask
	task ck(input ok);
		begin
			check_count = check_count + 1;
			if (!ok) begin
				num_errors = num_errors + 1;
				$display("Error at %0t: value mismatch", $time);
			end
		end
	endtask
	// ready is looked at half a cycle early; the handshake edge follows
	task wr(input [3:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
		reg [2:0] t, g;
		begin
			AWADDR <= a;
			WDATA <= d;
			WSTRB <= s;
			AWVALID <= 1'b1;
			WVALID <= 1'b1;
			BREADY <= 1'b1;
			t = 3'h7;
			while (t != 3'h0) begin
				@(negedge CLK);
				g = {AWVALID && AWREADY, WVALID && WREADY, BVALID && BREADY};
				if (g[0]) ck(BRESP === r);
				@(posedge CLK);
				if (g[2]) AWVALID <= 1'b0;
				if (g[1]) WVALID <= 1'b0;
				if (g[0]) BREADY <= 1'b0;
				t = t & ~g;
			end
			// an idle edge keeps a following call from redriving in this step
			@(posedge CLK);
		end
	endtask
	task rd(input [3:0] a, input [31:0] d, input [1:0] r);
		reg [1:0] t, g;
		begin
			ARADDR <= a;
			ARVALID <= 1'b1;
			RREADY <= 1'b1;
			t = 2'h3;
			while (t != 2'h0) begin
				@(negedge CLK);
				g = {ARVALID && ARREADY, RVALID && RREADY};
				if (g[0]) ck(RRESP === r && (r != `PDL_RESP_OKAY || RDATA === d));
				@(posedge CLK);
				if (g[1]) ARVALID <= 1'b0;
				if (g[0]) RREADY <= 1'b0;
				t = t & ~g;
			end
			@(posedge CLK);
		end
	endtask
	task wl(input want, input usb);
		begin
			for (n = 0; n < 3000 && (usb ? USB_LOCK : SYS_LOCK) !== want; n = n + 1)
				@(negedge CLK);
			ck((usb ? USB_LOCK : SYS_LOCK) === want);
			@(posedge CLK);
		end
	endtask
	// counts output rises over w cycles against e
	task cr(input usb, input integer w, input integer e);
		begin
			c = 0;
			@(negedge CLK);
			p = usb ? USB_CLK_OUT : SYS_CLK_OUT;
			repeat (w) begin
				@(negedge CLK);
				c = c + ((usb ? USB_CLK_OUT : SYS_CLK_OUT) && !p);
				p = usb ? USB_CLK_OUT : SYS_CLK_OUT;
			end
			ck(c === e);
			@(posedge CLK);
		end
	endtask
	// ****
	// tests
	// ****
	initial begin
		#2400000;
		num_errors = num_errors + 1;
		test_done;
	end
	initial begin
		cfg[0] = 8'h23;
		cfg[1] = 8'h42;
		cfg[2] = 8'h61;
		cfg[3] = 8'h04;
		cfg[4] = 8'h83;
		repeat (8) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
		rd(4'h0, 32'h100, `PDL_RESP_OKAY);
		rd(4'h4, 32'h100, `PDL_RESP_OKAY);
		rd(4'h8, 32'h0, `PDL_RESP_OKAY);
		rd(4'hC, 32'h0, `PDL_RESP_SLVERR);
		wr(4'hC, 32'h1, 4'hF, `PDL_RESP_SLVERR);
		wr(4'h8, 32'h3, 4'hF, `PDL_RESP_OKAY);
		rd(4'h8, 32'h0, `PDL_RESP_OKAY);
		for (i = 0; i < 5; i = i + 1) begin
			m = cfg[i][4:0] + 1;
			h = cfg[i][7] ? m : m << cfg[i][6:5];
			wr(4'h0, {23'h0, 1'b1, cfg[i]}, 4'hF, `PDL_RESP_OKAY);
			sys_half <= h[7:0];
			wr(4'h0, {24'h0, cfg[i]}, 4'hF, `PDL_RESP_OKAY);
			wl(1'b1, 1'b0);
			rd(4'h8, 32'h1, `PDL_RESP_OKAY);
			cr(1'b0, 8 * h, 4 * m);
			sys_half <= h[7:0] + 8'h2;
			wl(1'b0, 1'b0);
			wr(4'h0, {23'h0, 1'b1, cfg[i]}, 4'hF, `PDL_RESP_OKAY);
		end
		wr(4'h0, 32'h0, 4'h1, `PDL_RESP_OKAY);
		rd(4'h0, 32'h100, `PDL_RESP_OKAY);
		wr(4'h4, 32'h123, 4'hF, `PDL_RESP_OKAY);
		usb_half <= 8'h8;
		wr(4'h4, 32'h23, 4'hF, `PDL_RESP_OKAY);
		wl(1'b1, 1'b1);
		cr(1'b1, 64, 16);
		rd(4'h8, 32'h2, `PDL_RESP_OKAY);
		test_done;
	end
endmodule

// ---- logic/pdl_map.vh ----
/*
 * constants for the pll divider and lock control block:
 * register offsets, field positions, reset values and lock count.
 * assumes a 32-bit axi4-lite register bus with word aligned registers.
 */
`ifndef PDL_MAP_VH
`define PDL_MAP_VH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define PDL_OFF_CTRL0     4'h0
`define PDL_OFF_CTRL1     4'h4
`define PDL_OFF_STAT      4'h8

// ***************************************************************
// control fields
// ***************************************************************
`define PDL_RATIO_LSB     0
`define PDL_RATIO_W       5
`define PDL_PSEL_LSB      5
`define PDL_PSEL_W        2
`define PDL_BYP_BIT       7
`define PDL_PD_BIT        8
`define PDL_CTRL_RST      9'h100

// ***************************************************************
// lock detector and model
// ***************************************************************
`define PDL_LOCK_RUN      4'h9
`define PDL_ERR_LIMIT     8'h02
`define PDL_RESP_OKAY     2'h0
`define PDL_RESP_SLVERR   2'h2

`endif

// ---- logic/pdl_pll.v ----
/*
 * one pll instance: behavioural oscillator, post divider, feedback
 * divider, phase comparison and lock detector.
 * assumes ref_in already synchronised to clk, and clk fast enough
 * to act as the behavioural oscillator step.
 */
`timescale 1ns/1ns
`include "pdl_map.vh"

module pdl_pll (
	// clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// configuration
	input  wire       pd,
	input  wire       bypass,
	input  wire [4:0] ratio_sel,
	input  wire [1:0] psel,
	// reference and outputs
	input  wire       ref_in,
	output reg        clk_out,
	output reg        lock,
	output reg        fb_out
);

	// ***************************************************************
	// divider settings, taken only while held in reset
	// ***************************************************************
	reg  [4:0] ratio_sel_q;
	reg  [1:0] psel_q;
	reg        byp_q;
	reg  [3:0] p_val;
	reg        ref_q;
	reg        osc_q;
	reg  [3:0] pcnt_q;
	reg  [5:0] mcnt_q;
	reg  [7:0] err_q;
	reg  [3:0] run_q;
	wire       ref_rise;
	wire       out_rise;
	wire       fb_rise;
	reg        out_prev_q;
	reg        fb_prev_q;
	wire       next_out;
	reg        live_q;

	always @* begin
		case (psel_q)
		2'h0: p_val = 4'h1;
		2'h1: p_val = 4'h2;
		2'h2: p_val = 4'h4;
		default: p_val = 4'h8;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ratio_sel_q <= 5'h00;
			psel_q      <= 2'h0;
			byp_q       <= 1'b0;
		end else if (pd) begin
			// a ratio change lands only while dividers are in reset
			ratio_sel_q <= ratio_sel;
			psel_q      <= psel;
			byp_q       <= bypass;
		end
	end

	// ***************************************************************
	// oscillator and dividers
	// ***************************************************************
	// level the output clock takes at this edge, so feedback counts its rises
	assign next_out = byp_q ? ~osc_q :
		((pcnt_q == p_val - 4'h1) ? ~clk_out : clk_out);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_q  <= 1'b0;
			osc_q   <= 1'b0;
			pcnt_q  <= 4'h0;
			clk_out <= 1'b0;
			mcnt_q  <= 6'h00;
			fb_out  <= 1'b0;
		end else if (pd) begin
			live_q  <= 1'b0;
			osc_q   <= 1'b0;
			pcnt_q  <= 4'h0;
			clk_out <= 1'b0;
			mcnt_q  <= 6'h00;
			fb_out  <= 1'b0;
		end else if (!live_q) begin
			// no analog loop: the chain waits for a reference edge instead,
			// trading some start-up delay for a glitch-free first period
			osc_q   <= 1'b0;
			clk_out <= 1'b0;
			mcnt_q  <= 6'h00;
			fb_out  <= 1'b0;
			if (ref_rise) begin
				live_q <= 1'b1;
				// first output rise 2p-1 clocks on, so feedback meets reference
				pcnt_q <= 4'h1 - p_val;
			end
		end else begin
			osc_q <= ~osc_q;
			if (byp_q) begin
				clk_out <= ~osc_q;
			end else if (pcnt_q == p_val - 4'h1) begin
				// toggling every p clocks gives 2p and 50% duty
				pcnt_q  <= 4'h0;
				clk_out <= ~clk_out;
			end else begin
				pcnt_q <= pcnt_q + 4'h1;
			end
			if (next_out && !clk_out) begin
				// one feedback period per m output periods
				if (mcnt_q == {1'b0, ratio_sel_q}) begin
					mcnt_q <= 6'h00;
					fb_out <= 1'b1;
				end else begin
					mcnt_q <= mcnt_q + 6'h01;
					if (mcnt_q == {2'b00, ratio_sel_q[4:1]})
						fb_out <= 1'b0;
				end
			end else if (clk_out && !next_out && ratio_sel_q == 5'h00) begin
				// ratio of one: feedback simply follows the output clock
				fb_out <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// phase comparison and lock detector
	// ***************************************************************
	assign ref_rise = ref_in & ~ref_q;
	assign out_rise = clk_out & ~out_prev_q;
	assign fb_rise  = fb_out & ~fb_prev_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_q      <= 1'b0;
			out_prev_q <= 1'b0;
			fb_prev_q  <= 1'b0;
			err_q      <= 8'h00;
			run_q      <= 4'h0;
			lock       <= 1'b0;
		end else if (pd) begin
			ref_q      <= ref_in;
			out_prev_q <= 1'b0;
			fb_prev_q  <= 1'b0;
			err_q      <= 8'h00;
			run_q      <= 4'h0;
			lock       <= 1'b0;
		end else begin
			ref_q      <= ref_in;
			out_prev_q <= clk_out;
			fb_prev_q  <= fb_out;
			// error counts clocks between a reference edge and feedback edge
			if (ref_rise && fb_rise)
				err_q <= 8'h00;
			else if (ref_rise || fb_rise)
				err_q <= 8'h01;
			else if (err_q != 8'h00 && err_q != 8'hFF)
				err_q <= err_q + 8'h01;
			if (ref_rise) begin
				if (fb_rise || (err_q != 8'h00 && err_q <= `PDL_ERR_LIMIT)) begin
					if (run_q != `PDL_LOCK_RUN)
						run_q <= run_q + 4'h1;
					if (run_q >= `PDL_LOCK_RUN - 4'h1)
						lock <= 1'b1;
				end else begin
					run_q <= 4'h0;
					lock  <= 1'b0;
				end
			end
		end
	end

endmodule

// ---- logic/pdl_top.v ----
/*
 * pll divider and lock control: system pll and usb pll with an
 * axi4-lite register slave for dividers, bypass, power-down and lock.
 * assumes reference clocks arrive asynchronously on pins.
 */
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "pdl_map.vh"

module pdl_top (
	// clock and reset
	input  wire        CLK,
	input  wire        RSTN,
	// reference clock pins
	input  wire        SYS_REF_CLK,
	input  wire        USB_REF_CLK,
	// pll outputs
	output wire        SYS_CLK_OUT,
	output wire        SYS_LOCK,
	output wire        USB_CLK_OUT,
	output wire        USB_LOCK,
	// axi4-lite write address
	input  wire [3:0]  AWADDR,
	input  wire        AWVALID,
	output wire        AWREADY,
	// axi4-lite write data
	input  wire [31:0] WDATA,
	input  wire [3:0]  WSTRB,
	input  wire        WVALID,
	output wire        WREADY,
	// axi4-lite write response
	output reg  [1:0]  BRESP,
	output reg         BVALID,
	input  wire        BREADY,
	// axi4-lite read address
	input  wire [3:0]  ARADDR,
	input  wire        ARVALID,
	output wire        ARREADY,
	// axi4-lite read data
	output reg  [31:0] RDATA,
	output reg  [1:0]  RRESP,
	output reg         RVALID,
	input  wire        RREADY
);

	// ***************************************************************
	// control registers
	// ***************************************************************
	reg  [8:0]  ctrl0_q;
	reg  [8:0]  ctrl1_q;
	reg         aw_got_q;
	reg         w_got_q;
	reg  [3:0]  awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg  [1:0]  sys_sync_q;
	reg  [1:0]  usb_sync_q;
	wire        wr_go;
	reg  [31:0] rd_d;
	reg         rd_ok;

	// ***************************************************************
	// write channel
	// ***************************************************************
	assign AWREADY = !aw_got_q && !BVALID;
	assign WREADY  = !w_got_q && !BVALID;
	assign wr_go   = aw_got_q && w_got_q && !BVALID;

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
			BVALID   <= 1'b0;
			BRESP    <= `PDL_RESP_OKAY;
			ctrl0_q  <= `PDL_CTRL_RST;
			ctrl1_q  <= `PDL_CTRL_RST;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_got_q <= 1'b1;
				awaddr_q <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_got_q <= 1'b1;
				wdata_q <= WDATA;
				wstrb_q <= WSTRB;
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				BVALID   <= 1'b1;
				BRESP    <= `PDL_RESP_OKAY;
				case (awaddr_q)
				`PDL_OFF_CTRL0: begin
					if (wstrb_q[0])
						ctrl0_q[7:0] <= wdata_q[7:0];
					if (wstrb_q[1])
						ctrl0_q[8] <= wdata_q[8];
				end
				`PDL_OFF_CTRL1: begin
					if (wstrb_q[0])
						ctrl1_q[7:0] <= wdata_q[7:0];
					if (wstrb_q[1])
						ctrl1_q[8] <= wdata_q[8];
				end
				`PDL_OFF_STAT: ;
				default: BRESP <= `PDL_RESP_SLVERR;
				endcase
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// read channel
	// ***************************************************************
	assign ARREADY = !RVALID;

	always @* begin
		rd_d  = 32'h00000000;
		rd_ok = 1'b1;
		case (ARADDR)
		`PDL_OFF_CTRL0: rd_d[8:0] = ctrl0_q;
		`PDL_OFF_CTRL1: rd_d[8:0] = ctrl1_q;
		`PDL_OFF_STAT:  rd_d[1:0] = {USB_LOCK, SYS_LOCK};
		default:        rd_ok = 1'b0;
		endcase
	end

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h00000000;
			RRESP  <= `PDL_RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA  <= rd_d;
			RRESP  <= rd_ok ? `PDL_RESP_OKAY : `PDL_RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	// ***************************************************************
	// reference synchronisers
	// ***************************************************************
	// reference edges are only seen at clk rate, so phase error is coarse
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sys_sync_q <= 2'b00;
			usb_sync_q <= 2'b00;
		end else begin
			sys_sync_q <= {sys_sync_q[0], SYS_REF_CLK};
			usb_sync_q <= {usb_sync_q[0], USB_REF_CLK};
		end
	end

	// ***************************************************************
	// pll instances
	// ***************************************************************
	pdl_pll u_sys (
		.clk       (CLK),
		.rst_n     (RSTN),
		.pd        (ctrl0_q[`PDL_PD_BIT]),
		.bypass    (ctrl0_q[`PDL_BYP_BIT]),
		.ratio_sel (ctrl0_q[`PDL_RATIO_LSB +: `PDL_RATIO_W]),
		.psel      (ctrl0_q[`PDL_PSEL_LSB +: `PDL_PSEL_W]),
		.ref_in    (sys_sync_q[1]),
		.clk_out   (SYS_CLK_OUT),
		.lock      (SYS_LOCK),
		.fb_out    ()
	);

	// usb clock from an identical instance
	pdl_pll u_usb (
		.clk       (CLK),
		.rst_n     (RSTN),
		.pd        (ctrl1_q[`PDL_PD_BIT]),
		.bypass    (ctrl1_q[`PDL_BYP_BIT]),
		.ratio_sel (ctrl1_q[`PDL_RATIO_LSB +: `PDL_RATIO_W]),
		.psel      (ctrl1_q[`PDL_PSEL_LSB +: `PDL_PSEL_W]),
		.ref_in    (usb_sync_q[1]),
		.clk_out   (USB_CLK_OUT),
		.lock      (USB_LOCK),
		.fb_out    ()
	);

endmodule
